// >>> design/lcd_port_pin_switch.v
// Port/display pin switch: APB registers select port or display use of
// four backplane pins and eight digit pins, and gate their input paths.
// Assumes an APB master on clk; pads are asynchronous; display driver
// outputs are on clk.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`include "lcd_port_pin_switch_map.vh"

module lcd_port_pin_switch #(
	parameter BP_PINS    = 4,
	parameter DIGIT_PINS = 8,
	parameter ADDR_W     = 8
) (
	// Clock and reset
	input  wire                  clk,
	input  wire                  nrst,
	// APB slave
	input  wire                  psel,
	input  wire                  penable,
	input  wire                  pwrite,
	input  wire [ADDR_W-1:0]     paddr,
	input  wire [31:0]           pwdata,
	output wire [31:0]           prdata,
	output wire                  pready,
	output wire                  pslverr,
	// Backplane shared pins, port side
	input  wire [BP_PINS-1:0]    bp_port_dout,
	input  wire [BP_PINS-1:0]    bp_port_dir,
	output wire [BP_PINS-1:0]    bp_port_din,
	// Digit shared pins, port side
	input  wire [DIGIT_PINS-1:0] digit_port_dout,
	input  wire [DIGIT_PINS-1:0] digit_port_dir,
	output wire [DIGIT_PINS-1:0] digit_port_din,
	// Display driver side
	input  wire [BP_PINS-1:0]    common_drive,
	input  wire [DIGIT_PINS-1:0] segment_drive,
	output wire [3:0]            seg_low_select,
	// Backplane shared pins, pad side
	input  wire [BP_PINS-1:0]    bp_pad_in,
	output wire [BP_PINS-1:0]    bp_pad_out,
	output wire [BP_PINS-1:0]    bp_pad_oe_n,
	// Digit shared pins, pad side
	input  wire [DIGIT_PINS-1:0] digit_pad_in,
	output wire [DIGIT_PINS-1:0] digit_pad_out,
	output wire [DIGIT_PINS-1:0] digit_pad_oe_n
);

	localparam HALF = DIGIT_PINS / 2;

	reg  [3:0]            backplane_pin_select_reg;
	reg  [3:0]            backplane_pin_select_next;
	reg  [7:0]            display_control_one_reg;
	reg  [7:0]            display_control_one_next;
	reg  [31:0]           prdata_reg;
	reg  [31:0]           prdata_next;
	reg                   pslverr_reg;
	reg                   pslverr_next;
	reg  [BP_PINS-1:0]    bp_sel;
	reg  [BP_PINS-1:0]    bp_block;
	reg  [DIGIT_PINS-1:0] digit_sel;
	reg  [DIGIT_PINS-1:0] digit_block;
	wire                  upper_digit_drive_select;
	wire                  lower_digit_drive_select;
	wire                  setup_phase;
	wire                  access_phase;
	wire                  bps_hit;
	wire                  dc1_hit;
	wire                  lvl_hit;
	wire                  any_hit;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Word-aligned match; the two low address bits are ignored
	function addr_match;
		input [ADDR_W-1:0] addr;
		input [5:0]        index;
		begin
			addr_match = (addr[7:2] == index);
		end
	endfunction

	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable;
	assign bps_hit      = addr_match(paddr, `BACKPLANE_PIN_SELECT_INDEX);
	assign dc1_hit      = addr_match(paddr, `DISPLAY_CONTROL_ONE_INDEX);
	assign lvl_hit      = addr_match(paddr, `PIN_LEVEL_INDEX);
	assign any_hit      = bps_hit | dc1_hit | lvl_hit;

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Writes take effect only at the access edge, where pready is high
	always @* begin
		backplane_pin_select_next = backplane_pin_select_reg;
		display_control_one_next  = display_control_one_reg;
		if (access_phase && pwrite && bps_hit) begin
			// Upper bits of the byte are unimplemented
			backplane_pin_select_next =
				pwdata[`BACKPLANE_MSB:`BACKPLANE_LSB];
		end
		if (access_phase && pwrite && dc1_hit) begin
			display_control_one_next =
				pwdata[`DISPLAY_CONTROL_MSB:`DISPLAY_CONTROL_LSB] &
				`DISPLAY_CONTROL_WMASK;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			backplane_pin_select_reg <= `BACKPLANE_RESET;
			display_control_one_reg  <= `DISPLAY_CONTROL_RESET;
		end else begin
			backplane_pin_select_reg <= backplane_pin_select_next;
			display_control_one_reg  <= display_control_one_next;
		end
	end

	// ----------------------------------------------------------------
	// Read data and error
	// ----------------------------------------------------------------
	// Read data is latched in the setup cycle, so the access phase
	// completes with no wait state and prdata comes from a flip-flop.
	always @* begin
		prdata_next  = prdata_reg;
		pslverr_next = pslverr_reg;
		if (setup_phase) begin
			prdata_next  = `WORD_ZERO;
			pslverr_next = ~any_hit;
			if (!pwrite) begin
				if (bps_hit) begin
					prdata_next[`BACKPLANE_MSB:`BACKPLANE_LSB] =
						backplane_pin_select_reg;
				end
				if (dc1_hit) begin
					prdata_next[`DISPLAY_CONTROL_MSB:`DISPLAY_CONTROL_LSB] =
						display_control_one_reg;
				end
				if (lvl_hit) begin
					prdata_next[`PIN_LEVEL_BP_MSB:`PIN_LEVEL_BP_LSB] =
						bp_port_din;
					prdata_next[`PIN_LEVEL_DIGIT_MSB:`PIN_LEVEL_DIGIT_LSB] =
						digit_port_din;
				end
			end
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata_reg  <= `WORD_ZERO;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg  <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	assign pslverr = pslverr_reg & access_phase;

	// ----------------------------------------------------------------
	// Pin function selection
	// ----------------------------------------------------------------
	assign upper_digit_drive_select =
		display_control_one_reg[`UPPER_DIGIT_BIT];
	assign lower_digit_drive_select =
		display_control_one_reg[`LOWER_DIGIT_BIT];
	assign seg_low_select = display_control_one_reg[`SEG_LOW_MSB:0];

	integer i;

	always @* begin
		bp_sel      = {BP_PINS{1'b0}};
		bp_block    = {BP_PINS{1'b0}};
		digit_sel   = {DIGIT_PINS{1'b0}};
		digit_block = {DIGIT_PINS{1'b0}};
		for (i = 0; i < BP_PINS; i = i + 1) begin
			// Each pin follows its own select bit
			bp_sel[i]   = backplane_pin_select_reg[i];
			// The lowest bit kills input on the whole group
			bp_block[i] = backplane_pin_select_reg[0] | bp_sel[i];
		end
		for (i = 0; i < HALF; i = i + 1) begin
			digit_sel[i + HALF]   = upper_digit_drive_select;
			digit_block[i + HALF] = upper_digit_drive_select;
			digit_sel[i]          = lower_digit_drive_select;
			// Lower pins lose input while upper pins are segments
			// and lower pins are left on the port.
			digit_block[i] = lower_digit_drive_select |
				(upper_digit_drive_select &
				~lower_digit_drive_select);
		end
	end

	// ----------------------------------------------------------------
	// Pin cells
	// ----------------------------------------------------------------
	genvar g;

	generate
		for (g = 0; g < BP_PINS; g = g + 1) begin : bp_cell
			pin_switch_cell u_cell (
				.clk         (clk),
				.nrst        (nrst),
				.display_sel (bp_sel[g]),
				.input_block (bp_block[g]),
				.port_dout   (bp_port_dout[g]),
				.port_dir    (bp_port_dir[g]),
				.port_din    (bp_port_din[g]),
				.drive_dout  (common_drive[g]),
				.pad_in      (bp_pad_in[g]),
				.pad_out     (bp_pad_out[g]),
				.pad_oe_n    (bp_pad_oe_n[g])
			);
		end
		for (g = 0; g < DIGIT_PINS; g = g + 1) begin : digit_cell
			pin_switch_cell u_cell (
				.clk         (clk),
				.nrst        (nrst),
				.display_sel (digit_sel[g]),
				.input_block (digit_block[g]),
				.port_dout   (digit_port_dout[g]),
				.port_dir    (digit_port_dir[g]),
				.port_din    (digit_port_din[g]),
				.drive_dout  (segment_drive[g]),
				.pad_in      (digit_pad_in[g]),
				.pad_out     (digit_pad_out[g]),
				.pad_oe_n    (digit_pad_oe_n[g])
			);
		end
	endgenerate

endmodule

// >>> design/lcd_port_pin_switch_map.vh
// Register map and field layout of the display pin switch.
// Assumes APB word addressing: byte address is four times a register index.
`ifndef LCD_PORT_PIN_SWITCH_MAP_VH
`define LCD_PORT_PIN_SWITCH_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define BACKPLANE_PIN_SELECT_INDEX 6'h0B
`define DISPLAY_CONTROL_ONE_INDEX  6'h0C
`define PIN_LEVEL_INDEX            6'h0D

// ----------------------------------------------------------------
// Field positions in the 32-bit word view; digit and segment bits are within the control byte
// ----------------------------------------------------------------
`define BACKPLANE_LSB        8
`define BACKPLANE_MSB        11
`define DISPLAY_CONTROL_LSB  8
`define DISPLAY_CONTROL_MSB  15
`define UPPER_DIGIT_BIT      6
`define LOWER_DIGIT_BIT      5
`define SEG_LOW_MSB          3
`define PIN_LEVEL_BP_LSB     0
`define PIN_LEVEL_BP_MSB     3
`define PIN_LEVEL_DIGIT_LSB  8
`define PIN_LEVEL_DIGIT_MSB  15

// ----------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------
`define BACKPLANE_RESET       4'h0
`define DISPLAY_CONTROL_RESET 8'h00
`define DISPLAY_CONTROL_WMASK 8'h6F
`define WORD_ZERO             32'h0000_0000

`endif

// >>> design/pin_switch_cell.v
// One shared pin: port path or display drive path, with blockable input.
// Assumes pad_in is asynchronous to clk; all other inputs are on clk.
`timescale 1ns/100ps

module pin_switch_cell (
	// Clock and reset
	input  wire clk,
	input  wire nrst,
	// Selection
	input  wire display_sel,
	input  wire input_block,
	// Port logic side
	input  wire port_dout,
	input  wire port_dir,
	output wire port_din,
	// Display driver side
	input  wire drive_dout,
	// Pad side
	input  wire pad_in,
	output wire pad_out,
	output wire pad_oe_n
);

	reg sync1_reg;
	reg sync2_reg;
	reg port_din_reg;
	reg pad_out_reg;
	reg pad_oe_n_reg;

	// ----------------------------------------------------------------
	// Input synchroniser and blocking
	// ----------------------------------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_reg    <= 1'b0;
			sync2_reg    <= 1'b0;
			port_din_reg <= 1'b0;
		end else begin
			sync1_reg    <= pad_in;
			sync2_reg    <= sync1_reg;
			// Blocked input reads low, never the terminal level
			port_din_reg <= input_block ? 1'b0 : sync2_reg;
		end
	end

	// ----------------------------------------------------------------
	// Output path
	// ----------------------------------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pad_out_reg  <= 1'b0;
			pad_oe_n_reg <= 1'b1;
		end else if (display_sel) begin
			// Port data and direction are ignored here
			pad_out_reg  <= drive_dout;
			pad_oe_n_reg <= 1'b0;
		end else begin
			pad_out_reg  <= port_dout;
			pad_oe_n_reg <= ~port_dir;
		end
	end

	assign port_din = port_din_reg;
	assign pad_out  = pad_out_reg;
	assign pad_oe_n = pad_oe_n_reg;

endmodule

// >>> tb/lcd_port_pin_switch_assertions.sv
// Checker for the display pin switch, bound to its top module.
// Assumes zero-wait APB and the register layout of the map header.
`timescale 1ns/100ps
`include "lcd_port_pin_switch_map.vh"

module lcd_port_pin_switch_assertions #(
	parameter BP_PINS    = 4,
	parameter DIGIT_PINS = 8,
	parameter ADDR_W     = 8
) (
	input wire                  clk, nrst,
	input wire                  psel, penable, pwrite, pslverr,
	input wire [ADDR_W-1:0]     paddr,
	input wire [31:0]           pwdata, prdata,
	input wire [BP_PINS-1:0]    bp_port_dout, bp_port_dir, bp_port_din,
	input wire [BP_PINS-1:0]    common_drive, bp_pad_out, bp_pad_oe_n,
	input wire [DIGIT_PINS-1:0] digit_port_dout, segment_drive,
	input wire [DIGIT_PINS-1:0] digit_port_din, digit_pad_out
);
	// ----
	// Shadow of the select registers
	// ----
	reg  [3:0] bp_reg;
	reg  [7:0] dc_reg;
	wire       acc = psel & penable;
	wire [5:0] idx = paddr[7:2];
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bp_reg <= 4'h0;
			dc_reg <= 8'h00;
		end else if (acc & pwrite) begin
			if (idx == `BACKPLANE_PIN_SELECT_INDEX)
				bp_reg <= pwdata[11:8];
			if (idx == `DISPLAY_CONTROL_ONE_INDEX)
				dc_reg <= pwdata[15:8] & `DISPLAY_CONTROL_WMASK;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_bp_pad_route: assert property ($past(nrst) |-> bp_pad_out ==
		$past(bp_reg & common_drive | ~bp_reg & bp_port_dout)) else $error("bp pad level");
	a_bp_oe_owner: assert property ($past(nrst) |-> bp_pad_oe_n ==
		$past(~(bp_reg | bp_port_dir))) else $error("bp pad enable");
	a_backplane_select_0_block: assert property ($past(bp_reg[0]) |-> bp_port_din == 4'h0)
		else $error("bp input not blocked");
	a_upper_seg_route: assert property ($past(nrst) |-> digit_pad_out[7:4] ==
		$past(dc_reg[6] ? segment_drive[7:4] : digit_port_dout[7:4])) else $error("upper pads");
	a_lower_in_block: assert property ($past(dc_reg[6] & ~dc_reg[5]) |->
		digit_port_din[3:0] == 4'h0) else $error("lower input not blocked");
	a_bp_readback: assert property (acc & !pwrite & idx == `BACKPLANE_PIN_SELECT_INDEX |->
		prdata == {20'h0_0000, bp_reg, 8'h00}) else $error("bp readback");
	a_dc_readback: assert property (acc & !pwrite & idx == `DISPLAY_CONTROL_ONE_INDEX |->
		prdata == {16'h0000, dc_reg, 8'h00}) else $error("control readback");
	a_map_error: assert property (acc |-> pslverr == (idx < `BACKPLANE_PIN_SELECT_INDEX ||
		idx > `PIN_LEVEL_INDEX)) else $error("address decode");

	c_bp_backplane_select_0: cover property ($past(bp_reg[0]) && bp_reg == 4'hF);
	c_lower_block: cover property ($past(dc_reg[6] & ~dc_reg[5]));
	c_unmapped: cover property (acc & pslverr);
endmodule

bind lcd_port_pin_switch lcd_port_pin_switch_assertions #(
	.BP_PINS(BP_PINS), .DIGIT_PINS(DIGIT_PINS), .ADDR_W(ADDR_W)
) i_chk (
	.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.bp_port_dout(bp_port_dout), .bp_port_dir(bp_port_dir), .bp_port_din(bp_port_din),
	.common_drive(common_drive), .bp_pad_out(bp_pad_out), .bp_pad_oe_n(bp_pad_oe_n),
	.digit_port_dout(digit_port_dout), .segment_drive(segment_drive),
	.digit_port_din(digit_port_din), .digit_pad_out(digit_pad_out)
);

// >>> tb/lcd_port_pin_switch_bench.sv
// Self-checking bench of the display pin switch.
// Assumes the design and map header are on the include path.
`timescale 1ns/100ps

`define CHK(n, x, s) begin checked++; if ((s) !== (x)) begin error_cnt++; \
	$display("ERROR %s exp %h got %h", n, x, s); end end

module lcd_port_pin_switch_bench;
	reg         clk, nrst, psel, penable, pwrite, pin_chk, lb;
	reg  [7:0]  paddr;
	reg  [31:0] pwdata, w;
	reg  [3:0]  bd, bdir, cd, bpi, bp;
	reg  [7:0]  dd, ddir, sd, dpi, dc, m;
	wire [31:0] prdata;
	wire        pready, pslverr;
	wire [3:0]  bdin, bout, boe, seg;
	wire [7:0]  ddin, dout, doe;
	reg  [32:0] e, rq[$];
	reg  [27:0] p, pq[$];
	integer     error_cnt = 0, checked = 0, k;

	lcd_port_pin_switch i_dut (
		.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bp_port_dout(bd), .bp_port_dir(bdir), .bp_port_din(bdin),
		.digit_port_dout(dd), .digit_port_dir(ddir), .digit_port_din(ddin),
		.common_drive(cd), .segment_drive(sd), .seg_low_select(seg),
		.bp_pad_in(bpi), .bp_pad_out(bout), .bp_pad_oe_n(boe),
		.digit_pad_in(dpi), .digit_pad_out(dout), .digit_pad_oe_n(doe)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----
	// Drivers
	// ----
	task apb(input [7:0] a, input wr, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			while (pready !== 1'b1)
				@(posedge clk);
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask

	task rd(input [7:0] a, input [32:0] x);
		begin
			rq.push_back(x);
			apb(a, 1'b0, 32'h0000_0000);
		end
	endtask

	task pins(input [27:0] x);
		begin
			pq.push_back(x);
			pin_chk <= 1'b1;
			@(posedge clk);
			pin_chk <= 1'b0;
			@(posedge clk);
		end
	endtask

	task finish_test;
		begin
			$display("checked %0d error_cnt %0d", checked, error_cnt);
			if (error_cnt == 0 && checked > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask

	// ----
	// Monitor
	// ----
	always @(posedge clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
			e = rq.pop_front();
			`CHK("read", e, {pslverr, prdata})
		end
		if (pin_chk === 1'b1) begin
			p = pq.pop_front();
			`CHK("pins", p, {seg, doe, dout, boe, bout})
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test;
	end

	initial begin
		{psel, penable, pwrite, pin_chk, nrst} = 5'h00;
		{paddr, pwdata} = 40'h00_0000_0000;
		{bd, bdir, cd, bpi, dd, ddir, sd, dpi} = 48'h0000_0000_0000;
		w = $urandom(9464);
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(8'h2C, 33'h0_0000_0000);
		rd(8'h30, 33'h0_0000_0000);
		for (k = 0; k < 8; k++) begin
			w = $urandom;
			bp = (k == 1) ? 4'h1 : (k == 2) ? 4'hF : (k == 0) ? 4'h0 : w[3:0];
			dc = w[11:4];
			dc[6:5] = k[1:0];
			w = $urandom;
			w[11:8] = bp;
			apb(8'h2C, 1'b1, w);
			w = $urandom;
			w[15:8] = dc;
			apb(8'h30, 1'b1, w);
			dc = dc & 8'h6F;
			rd(8'h2C, {21'h00_0000, bp, 8'h00});
			rd(8'h30, {17'h0_0000, dc, 8'h00});
			{bd, bdir, cd, bpi, dd, ddir} <= $urandom;
			w = $urandom;
			sd <= w[15:8];
			dpi <= w[7:0];
			repeat (4) @(posedge clk);
			m = {{4{dc[6]}}, {4{dc[5]}}};
			lb = dc[5] | dc[6];
			pins({dc[3:0], ~(m | ddir), m & sd | ~m & dd, ~(bp | bdir), bp & cd | ~bp & bd});
			// Segment-owned upper pins read low as well
			m = {{4{dc[6]}}, {4{lb}}};
			rd(8'h34, {17'h0_0000, dpi & ~m, 4'h0, bpi & ~(bp[0] ? 4'hF : bp)});
		end
		// Mid-run reset must clear select bits that were set
		apb(8'h2C, 1'b1, 32'h0000_0F00);
		apb(8'h30, 1'b1, 32'h0000_6F00);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(8'h2C, 33'h0_0000_0000);
		rd(8'h30, 33'h0_0000_0000);
		pins({4'h0, ~ddir, dd, ~bdir, bd});
		apb(8'h3C, 1'b1, 32'hFFFF_FFFF);
		rd(8'h3C, {1'b1, 32'h0000_0000});
		rd(8'h01, {1'b1, 32'h0000_0000});
		finish_test;
	end
endmodule
